// [att_throttle.sv]
// adaptive thermal throttle controller, top level
//
// How it works
// - activate when any sensor reaches the limit
// - limit is ceiling field minus offset field
// - software writes offset in whole degrees
// - offset resets to zero degrees
// - ceiling is fused, readable, never written
// - offset write leaves reported ceiling unchanged
// - protection cannot be disabled
// - keep lowering both domains while hot
// - return to normal point once cool
// - going up: voltage first, then frequency
// - going down: frequency first, then voltage
// - stall execution during each frequency change
// - higher software request waits for event end
// - lower software request applies at once
// - modulate when hot at minimum point
// - modulation runs one quarter, stops three
// - modulation period fixed absolute time
// - deactivate after cool and hysteresis expired
// - snoop clock never gated
`timescale 1ns/1ps
`include "att_defs.svh"
module att_throttle #(
    parameter int unsigned STEP_CYCLES = `ATT_STEP_CYC,
    parameter int unsigned HYST_CYCLES = `ATT_HYST_CYC
) (
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    // temperature sensors, absolute degrees Celsius
    input  wire logic [`ATT_NSENS-1:0][7:0]    sensor_temp,
    input  wire logic [`ATT_NSENS-1:0]         sensor_valid,
    // factory fused junction ceiling
    input  wire logic [7:0]                    ceiling_fuse,
    // register port
    input  wire att_pkg::att_reg_req_t         reg_req,
    output logic [63:0]                        reg_rdata,
    output logic                               reg_ack,
    output logic                               reg_err,
    // software performance state request
    input  wire logic                          pst_req,
    input  wire logic [3:0]                    pst_level,
    output logic                               pst_pending,
    // operating point to the frequency and voltage control
    output att_pkg::att_op_t                   core_op,
    output att_pkg::att_op_t                   gfx_op,
    // core clock and execution control
    output logic                               exec_stall,
    output logic                               exec_clk_run,
    output logic                               snoop_clk_run,
    // status
    output logic                               throttle_active,
    output logic                               modulating
);
    localparam logic [15:0] STEP_LOAD = 16'(STEP_CYCLES - 1);
    localparam logic [15:0] HYST_LOAD = 16'(HYST_CYCLES);

    function automatic logic reg_hit(input logic [15:0] addr);
        reg_hit = (addr == `ATT_REG_THERMAL_TARGET);
    endfunction

    // ceiling capture and offset register
    logic [7:0]  junction_ceiling;
    logic        ceil_loaded;
    logic [5:0]  act_offset;

    // thermal state
    logic [8:0]  next_diff;
    logic [7:0]  threshold;
    logic [`ATT_NSENS-1:0] sensor_hot;
    logic        temp_hot;
    logic        active;
    logic [15:0] hyst_cnt;
    logic [15:0] step_cnt;
    logic [3:0]  therm_level;
    logic [3:0]  sw_level;
    logic [3:0]  next_target;
    logic        mod_en;

    // sequencer and modulator
    att_pkg::att_op_t applied;
    logic        freq_changing;
    logic        mod_run;

    // fuse is sampled once after reset release, not under the reset itself
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            junction_ceiling <= `ATT_CEIL_RESET;
            ceil_loaded      <= 1'b0;
        end else if (!ceil_loaded) begin
            junction_ceiling <= ceiling_fuse;
            ceil_loaded      <= 1'b1;
        end
    end

    // only the offset field is writable; the ceiling field has no write path
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            act_offset <= `ATT_OFS_RESET;
        end else if (reg_req.wr && reg_hit(reg_req.addr)) begin
            act_offset <= reg_req.wdata[`ATT_OFS_MSB:`ATT_OFS_LSB];
        end
    end

    // an offset larger than the ceiling floors the limit at zero
    always_comb begin
        next_diff = {1'b0, junction_ceiling} - {3'b000, act_offset};
        if (next_diff[8]) begin
            threshold = 8'h00;
        end else begin
            threshold = next_diff[7:0];
        end
    end

    for (genvar i = 0; i < `ATT_NSENS; i++) begin : g_sense
        assign sensor_hot[i] = sensor_valid[i] && (sensor_temp[i] >= threshold);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            temp_hot <= 1'b0;
        end else begin
            temp_hot <= |sensor_hot;
        end
    end

    // no enable bit exists anywhere, so the monitor always responds
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hyst_cnt <= 16'h0000;
        end else if (temp_hot) begin
            hyst_cnt <= HYST_LOAD;
        end else if (hyst_cnt != 16'h0000) begin
            hyst_cnt <= hyst_cnt - 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
        end else if (temp_hot) begin
            active <= 1'b1;
        end else if (hyst_cnt == 16'h0000) begin
            active <= 1'b0;
        end
    end

    // step timer idles at zero when cool, so a new event steps at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt <= 16'h0000;
        end else if (!temp_hot) begin
            step_cnt <= 16'h0000;
        end else if (step_cnt == 16'h0000) begin
            step_cnt <= STEP_LOAD;
        end else begin
            step_cnt <= step_cnt - 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            therm_level <= `ATT_LEVEL_MAX;
        end else if (!temp_hot) begin
            therm_level <= `ATT_LEVEL_MAX;
        end else if (step_cnt == 16'h0000 && therm_level != `ATT_LEVEL_MIN) begin
            therm_level <= therm_level - 4'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sw_level <= `ATT_LEVEL_MAX;
        end else if (pst_req) begin
            sw_level <= pst_level;
        end
    end

    // the software request is held, not dropped, and wins again after the event
    always_comb begin
        if (active && sw_level > therm_level) begin
            next_target = therm_level;
        end else begin
            next_target = sw_level;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pst_pending <= 1'b0;
        end else begin
            pst_pending <= active && (sw_level > therm_level);
        end
    end

    // once engaged, modulation holds until the event itself ends
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mod_en <= 1'b0;
        end else if (!active) begin
            mod_en <= 1'b0;
        end else if (temp_hot && therm_level == `ATT_LEVEL_MIN &&
                     applied.freq == `ATT_LEVEL_MIN && applied.volt == `ATT_LEVEL_MIN) begin
            mod_en <= 1'b1;
        end
    end

    att_opseq u_opseq (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .target        (next_target),
        .applied       (applied),
        .freq_changing (freq_changing)
    );

    att_clkmod u_clkmod (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .enable (mod_en),
        .run    (mod_run)
    );

    // both domains track the same throttle point
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            core_op <= '{freq: `ATT_LEVEL_MAX, volt: `ATT_LEVEL_MAX};
            gfx_op  <= '{freq: `ATT_LEVEL_MAX, volt: `ATT_LEVEL_MAX};
        end else begin
            core_op <= applied;
            gfx_op  <= applied;
        end
    end

    // snoop clock is kept apart from the modulated execution clock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            exec_stall    <= 1'b0;
            exec_clk_run  <= 1'b1;
            snoop_clk_run <= 1'b1;
            modulating    <= 1'b0;
        end else begin
            exec_stall    <= freq_changing;
            exec_clk_run  <= mod_run;
            snoop_clk_run <= 1'b1;
            modulating    <= mod_en;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            throttle_active <= 1'b0;
        end else begin
            throttle_active <= active;
        end
    end

    // unmapped accesses still answer with an error flag; unmapped reads return zero data, unmapped writes leave read data as it was
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_ack   <= 1'b0;
            reg_err   <= 1'b0;
            reg_rdata <= 64'h0000_0000_0000_0000;
        end else begin
            reg_ack <= reg_req.rd || reg_req.wr;
            reg_err <= (reg_req.rd || reg_req.wr) && !reg_hit(reg_req.addr);
            if (reg_req.rd && reg_hit(reg_req.addr)) begin
                reg_rdata <= 64'h0000_0000_0000_0000;
                reg_rdata[`ATT_CEIL_MSB:`ATT_CEIL_LSB] <= junction_ceiling;
                reg_rdata[`ATT_OFS_MSB:`ATT_OFS_LSB]   <= act_offset;
                reg_rdata[`ATT_ACTIVE_BIT]             <= active;
            end else if (reg_req.rd) begin
                reg_rdata <= 64'h0000_0000_0000_0000;
            end
        end
    end

endmodule // att_throttle

// [att_defs.svh]
// register layout, reset values and timing counts for the thermal throttle
`ifndef ATT_DEFS_SVH
`define ATT_DEFS_SVH

`define ATT_REG_THERMAL_TARGET 16'h01A2
`define ATT_CEIL_LSB           16
`define ATT_CEIL_MSB           23
`define ATT_OFS_LSB            24
`define ATT_OFS_MSB            29
`define ATT_ACTIVE_BIT         32
`define ATT_OFS_RESET          6'h00
`define ATT_CEIL_RESET         8'h00

`define ATT_LEVEL_MAX          4'hF
`define ATT_LEVEL_MIN          4'h0
`define ATT_NSENS              4

`define ATT_CLK_MHZ            25
`define ATT_MOD_PERIOD_US      32
`define ATT_MOD_PERIOD_CYC     (`ATT_MOD_PERIOD_US * `ATT_CLK_MHZ)
`define ATT_MOD_ON_CYC         (`ATT_MOD_PERIOD_CYC / 4)
`define ATT_VOLT_SETTLE_US     2
`define ATT_VOLT_SETTLE_CYC    (`ATT_VOLT_SETTLE_US * `ATT_CLK_MHZ)
`define ATT_FREQ_SETTLE_US     1
`define ATT_FREQ_SETTLE_CYC    (`ATT_FREQ_SETTLE_US * `ATT_CLK_MHZ)
`define ATT_STEP_US            1000
`define ATT_STEP_CYC           (`ATT_STEP_US * `ATT_CLK_MHZ)
`define ATT_HYST_US            100
`define ATT_HYST_CYC           (`ATT_HYST_US * `ATT_CLK_MHZ)

`endif

// [att_pkg.sv]
// types shared by the thermal throttle modules
package att_pkg;

    typedef struct packed {
        logic [3:0] freq;
        logic [3:0] volt;
    } att_op_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [63:0] wdata;
    } att_reg_req_t;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_VOLT_UP,
        SEQ_FREQ_UP,
        SEQ_FREQ_DN,
        SEQ_VOLT_DN
    } att_seq_state_t;

endpackage

// [att_clkmod.sv]
// fixed duty clock modulator: a quarter of each period running
`timescale 1ns/1ps
`include "att_defs.svh"
module att_clkmod (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // control
    input  wire logic enable,
    output logic      run
);
    localparam logic [9:0] PERIOD = 10'(`ATT_MOD_PERIOD_CYC);
    localparam logic [9:0] ON_CYC = 10'(`ATT_MOD_ON_CYC);

    logic [9:0] phase;

    // period counted in mclk cycles, so it does not follow core frequency
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 10'h000;
        end else if (!enable || phase == PERIOD - 10'h001) begin
            phase <= 10'h000;
        end else begin
            phase <= phase + 10'h001;
        end
    end

    assign run = !enable || (phase < ON_CYC);

endmodule // att_clkmod

// [att_opseq.sv]
// operating point sequencer: orders voltage and frequency moves
`timescale 1ns/1ps
`include "att_defs.svh"
module att_opseq (
    // clock and reset
    input  wire logic            mclk,
    input  wire logic            rst_n,
    // request
    input  wire logic [3:0]      target,
    // state
    output att_pkg::att_op_t     applied,
    output logic                 freq_changing
);
    localparam logic [7:0] VSET = 8'(`ATT_VOLT_SETTLE_CYC);
    localparam logic [7:0] FSET = 8'(`ATT_FREQ_SETTLE_CYC);

    att_pkg::att_seq_state_t state;
    logic [7:0]              timer;
    logic [3:0]              goal;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= att_pkg::SEQ_IDLE;
            timer   <= 8'h00;
            goal    <= `ATT_LEVEL_MAX;
            applied <= '{freq: `ATT_LEVEL_MAX, volt: `ATT_LEVEL_MAX};
        end else if (timer != 8'h00) begin
            timer <= timer - 8'h01;
        end else begin
            case (state)
                att_pkg::SEQ_IDLE: begin
                    if (target > applied.freq) begin
                        applied.volt <= target;
                        goal         <= target;
                        timer        <= VSET;
                        state        <= att_pkg::SEQ_VOLT_UP;
                    end else if (target < applied.freq) begin
                        applied.freq <= target;
                        goal         <= target;
                        timer        <= FSET;
                        state        <= att_pkg::SEQ_FREQ_DN;
                    end
                end
                att_pkg::SEQ_VOLT_UP: begin
                    applied.freq <= goal;
                    timer        <= FSET;
                    state        <= att_pkg::SEQ_FREQ_UP;
                end
                att_pkg::SEQ_FREQ_DN: begin
                    applied.volt <= goal;
                    timer        <= VSET;
                    state        <= att_pkg::SEQ_VOLT_DN;
                end
                default: begin
                    state <= att_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    assign freq_changing = (state == att_pkg::SEQ_FREQ_UP) ||
                           (state == att_pkg::SEQ_FREQ_DN);

endmodule // att_opseq

// [att_throttle_chk.sv]
// concurrent checks on the thermal throttle top-level ports
`timescale 1ns/1ps
`include "att_defs.svh"
module att_throttle_chk #(
    parameter int unsigned STEP_CYCLES = 20,
    parameter int unsigned HYST_CYCLES = 10
) (
    // clock and reset
    input wire logic                       mclk,
    input wire logic                       rst_n,
    // sensors and fuse
    input wire logic [`ATT_NSENS-1:0][7:0] sensor_temp,
    input wire logic [`ATT_NSENS-1:0]      sensor_valid,
    input wire logic [7:0]                 ceiling_fuse,
    // register port
    input wire att_pkg::att_reg_req_t      reg_req,
    input wire logic [63:0]                reg_rdata,
    input wire logic                       reg_ack,
    input wire logic                       reg_err,
    // control and status
    input wire logic                       pst_pending,
    input wire att_pkg::att_op_t           core_op,
    input wire att_pkg::att_op_t           gfx_op,
    input wire logic                       exec_stall,
    input wire logic                       exec_clk_run,
    input wire logic                       snoop_clk_run,
    input wire logic                       throttle_active,
    input wire logic                       modulating
);
    localparam logic [15:0] MAP = `ATT_REG_THERMAL_TARGET;
    logic [5:0]  ofs;
    logic [8:0]  thr;
    logic        hot;
    logic [9:0]  low_cnt;
    logic [15:0] cool_cnt;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    always_comb begin
        thr = {1'b0, ceiling_fuse} - {3'h0, ofs};
        hot = 1'b0;
        for (int i = 0; i < `ATT_NSENS; i++) begin
            // a negative limit floors at zero, so any valid reading counts
            if (sensor_valid[i] && (thr[8] || {1'b0, sensor_temp[i]} >= thr)) hot = 1'b1;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) ofs <= 6'h00;
        else if (reg_req.wr && reg_req.addr == MAP) ofs <= reg_req.wdata[29:24];
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) low_cnt <= 10'h000;
        else if (exec_clk_run) low_cnt <= 10'h000;
        else if (low_cnt != 10'h3FF) low_cnt <= low_cnt + 10'h001;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) cool_cnt <= 16'h0000;
        else if (hot) cool_cnt <= 16'h0000;
        else if (cool_cnt != 16'hFFFF) cool_cnt <= cool_cnt + 16'h0001;
    end

    sequence s_access;
        reg_req.wr || reg_req.rd;
    endsequence
    sequence s_map_read;
        reg_req.rd && reg_req.addr == MAP;
    endsequence

    a_snoop_clk_on: assert property (snoop_clk_run)
        else $error("snoop clock gated");
    a_ops_paired: assert property (core_op == gfx_op)
        else $error("core and graphics points differ");
    a_volt_leads_freq: assert property (core_op.freq <= core_op.volt)
        else $error("frequency above voltage level");
    a_stall_on_step: assert property ($changed(core_op.freq) |-> exec_stall)
        else $error("frequency moved without stall");
    a_reg_ack: assert property (s_access |=> reg_ack)
        else $error("register access not acknowledged");
    a_unmapped_err: assert property (s_access ##0 reg_req.addr != MAP |=> reg_err)
        else $error("unmapped access without error");
    a_ceil_readback: assert property (s_map_read |=> reg_rdata ==
        {31'h0, throttle_active, 2'h0, $past(ofs), ceiling_fuse, 16'h0})
        else $error("thermal target read wrong");
    a_hot_activates: assert property (hot |-> ##[1:3] throttle_active)
        else $error("hot reading did not activate");
    a_hyst_release: assert property ($fell(throttle_active) |-> cool_cnt >= HYST_CYCLES)
        else $error("released before hysteresis");
    a_mod_off_time: assert property ($rose(exec_clk_run) && $past(modulating) && modulating
        |-> low_cnt == 10'h258)
        else $error("modulation off time wrong");
    a_pend_active: assert property (pst_pending |-> throttle_active)
        else $error("request held while inactive");
endmodule // att_throttle_chk

bind att_throttle att_throttle_chk #(.STEP_CYCLES(STEP_CYCLES), .HYST_CYCLES(HYST_CYCLES)) u_chk (
    .mclk(mclk), .rst_n(rst_n), .sensor_temp(sensor_temp), .sensor_valid(sensor_valid),
    .ceiling_fuse(ceiling_fuse), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .reg_err(reg_err), .pst_pending(pst_pending), .core_op(core_op), .gfx_op(gfx_op),
    .exec_stall(exec_stall), .exec_clk_run(exec_clk_run), .snoop_clk_run(snoop_clk_run),
    .throttle_active(throttle_active), .modulating(modulating));

// [att_sens_model.sv]
// temperature sensor bank model: one probe at the set point, the rest cooler
`timescale 1ns/1ps
`include "att_defs.svh"
module att_sens_model (
    // clock
    input  wire logic                  mclk,
    // set point
    input  wire logic [7:0]            t_set,
    input  wire logic [1:0]            hot_idx,
    input  wire logic [`ATT_NSENS-1:0] v_mask,
    // sensor bank
    output logic [`ATT_NSENS-1:0][7:0] sensor_temp,
    output logic [`ATT_NSENS-1:0]      sensor_valid
);
    initial sensor_temp = '0;
    initial sensor_valid = '0;
    always @(posedge mclk) begin
        sensor_valid <= v_mask;
        for (int i = 0; i < `ATT_NSENS; i++) begin
            // an invalid probe wanders so a stale value is never trusted
            if (!v_mask[i]) sensor_temp[i] <= ~sensor_temp[i];
            else if (i == hot_idx) sensor_temp[i] <= t_set;
            else sensor_temp[i] <= t_set - 8'h03;
        end
    end
endmodule // att_sens_model

// [tb_adaptive_thermal_throttle.sv]
// self-checking bench for the adaptive thermal throttle
`timescale 1ns/1ps
`include "att_defs.svh"
module tb_adaptive_thermal_throttle;
    localparam logic [7:0]  CEIL = 8'h5A; // arbitrary fused ceiling
    localparam logic [15:0] MAP  = `ATT_REG_THERMAL_TARGET;
    logic                       mclk, rst_n, pst_req, pst_pending, e;
    logic [7:0]                 t_set;
    logic [1:0]                 hot_idx;
    logic [3:0]                 v_mask, pst_level;
    logic [`ATT_NSENS-1:0][7:0] sensor_temp;
    logic [`ATT_NSENS-1:0]      sensor_valid;
    att_pkg::att_reg_req_t      reg_req;
    logic [63:0]                reg_rdata, q;
    logic                       reg_ack, reg_err, exec_stall, exec_clk_run, snoop_clk_run;
    att_pkg::att_op_t           core_op, gfx_op;
    logic                       throttle_active, modulating;
    logic [31:0]                lfsr;
    int                         mismatches, num_checks, cyc, n;

    att_throttle #(.STEP_CYCLES(20), .HYST_CYCLES(10)) dut (
        .mclk(mclk), .rst_n(rst_n), .sensor_temp(sensor_temp), .sensor_valid(sensor_valid),
        .ceiling_fuse(CEIL), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_err(reg_err), .pst_req(pst_req), .pst_level(pst_level),
        .pst_pending(pst_pending), .core_op(core_op), .gfx_op(gfx_op),
        .exec_stall(exec_stall), .exec_clk_run(exec_clk_run), .snoop_clk_run(snoop_clk_run),
        .throttle_active(throttle_active), .modulating(modulating));
    att_sens_model sens (.mclk(mclk), .t_set(t_set), .hot_idx(hot_idx), .v_mask(v_mask),
        .sensor_temp(sensor_temp), .sensor_valid(sensor_valid));

    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [63:0] exp_reg(logic act, logic [5:0] ofs);
        return {31'h0, act, 2'h0, ofs, CEIL, 16'h0};
    endfunction
    task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic reg_op(logic wr, logic [15:0] a, logic [63:0] d);
        @(negedge mclk);
        reg_req = '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(negedge mclk);
        reg_req = '0;
        q = reg_rdata;
        e = reg_err;
        chk("reg_ack", 64'h1, reg_ack);
    endtask
    task automatic pst(logic [3:0] lvl);
        @(negedge mclk);
        pst_req = 1'b1;
        pst_level = lvl;
        @(negedge mclk);
        pst_req = 1'b0;
    endtask
    task automatic wait_op(logic [7:0] op, int lim);
        for (int i = 0; i < lim && core_op !== op; i++) @(negedge mclk);
    endtask
    task automatic end_sim();
        if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        rst_n = 1'b0;
        reg_req = '0;
        pst_req = 1'b0;
        pst_level = 4'hF;
        t_set = 8'h20;
        hot_idx = 2'h0;
        v_mask = 4'h0;
        lfsr = 32'h8ddd_53e7;
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        chk("op_reset", 64'hFF, core_op);
        reg_op(1'b0, MAP, '0);
        chk("tt_reset", exp_reg(1'b0, 6'h00), q);
        reg_op(1'b1, MAP, 64'hFFFF_FFFF_C5FF_FFFF);
        reg_op(1'b0, MAP, '0);
        chk("tt_ofs", exp_reg(1'b0, 6'h05), q);
        reg_op(1'b0, MAP + 16'h0001, '0);
        chk("err_rd", 64'h1, e);
        chk("err_data", 64'h0, q);
        reg_op(1'b1, 16'h0000, '1);
        chk("err_wr", 64'h1, e);
        // random cool readings stay below the lowered limit
        for (int k = 0; k < 8; k++) begin
            lfsr = lfsr_next(lfsr);
            v_mask = lfsr[3:0];
            hot_idx = lfsr[5:4];
            t_set = 8'h14 + {3'h0, lfsr[12:8]};
            repeat (8) @(negedge mclk);
            chk("cool_idle", 64'h0, throttle_active);
        end
        v_mask = 4'hF;
        t_set = CEIL - 8'h06;
        repeat (8) @(negedge mclk);
        chk("below_limit", 64'h0, throttle_active);
        lfsr = lfsr_next(lfsr);
        hot_idx = lfsr[1:0];
        t_set = CEIL - 8'h05;
        repeat (6) @(negedge mclk);
        chk("hot_active", 64'h1, throttle_active);
        reg_op(1'b0, MAP, '0);
        chk("tt_active", exp_reg(1'b1, 6'h05), q);
        pst(4'hF);
        @(negedge mclk);
        chk("pst_defer", 64'h1, pst_pending);
        wait_op(8'h00, 4000);
        repeat (4) @(negedge mclk);
        chk("mod_on", 64'h1, modulating);
        repeat (1700) @(negedge mclk);
        chk("still_min", 64'h0, core_op);
        t_set = 8'h20;
        for (n = 0; n < 200 && throttle_active; n++) @(negedge mclk);
        chk("released", 64'h0, throttle_active);
        @(negedge mclk);
        chk("mod_off", 64'h0, modulating);
        chk("clk_run", 64'h1, exec_clk_run);
        chk("pst_free", 64'h0, pst_pending);
        wait_op(8'hFF, 3000);
        chk("op_back", 64'hFF, core_op);
        t_set = CEIL;
        for (n = 0; n < 20 && !throttle_active; n++) @(negedge mclk);
        pst(4'h2);
        for (n = 0; n < 160 && core_op.freq > 4'h2; n++) @(negedge mclk);
        chk("pst_now", 64'h2, core_op.freq);
        t_set = 8'h20;
        end_sim();
    end
endmodule // tb_adaptive_thermal_throttle
